// [hdl/ccp_defs.svh]
// Constants for the capture/compare/PWM channel
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

`define CCP_CTRL_RST    8'h00
`define CCP_CTRL_WMASK  8'h9F
`define CCP_EN_BIT      7
`define CCP_OUT_BIT     5
`define CCP_FMT_BIT     4
`define CCP_VALUE_RST   16'h0000
`define CCP_DUTY_RST    10'h000

`define CCP_M_OFF       4'h0
`define CCP_M_TOG_CLR   4'h1
`define CCP_M_TOG       4'h2
`define CCP_M_CAP_ANY   4'h3
`define CCP_M_CAP_FALL  4'h4
`define CCP_M_CAP_RISE  4'h5
`define CCP_M_CAP_R4    4'h6
`define CCP_M_CAP_R16   4'h7
`define CCP_M_SET       4'h8
`define CCP_M_CLR       4'h9
`define CCP_M_PULSE     4'hA
`define CCP_M_PULSE_CLR 4'hB
`define CCP_M_PWM_LO    4'hC

`define CCP_PS4_LAST    4'h3
`define CCP_PS16_LAST   4'hF

`endif

// [hdl/ccp_edge_cnt.sv]
// Capture edge detector with rising-edge prescaler
`timescale 1ns/1ps
`include "ccp_defs.svh"
module ccp_edge_cnt (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       clr_i,
    input  wire logic       run_i,
    input  wire logic [3:0] mode_i,
    input  wire logic       in_i,
    output logic            hit_o
);
    logic       prev_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       rise;
    logic       fall;
    logic       r4_mode;
    logic       r16_mode;
    logic       wrap;

    assign rise     = run_i & in_i & ~prev_reg;
    assign fall     = run_i & ~in_i & prev_reg;
    assign r4_mode  = (mode_i == `CCP_M_CAP_R4);
    assign r16_mode = (mode_i == `CCP_M_CAP_R16);
    assign wrap     = (r4_mode & cnt_reg == `CCP_PS4_LAST)
                    | (r16_mode & cnt_reg == `CCP_PS16_LAST);

    assign hit_o = ~clr_i & (
          ((mode_i == `CCP_M_CAP_ANY)  & (rise | fall))
        | ((mode_i == `CCP_M_CAP_FALL) & fall)
        | ((mode_i == `CCP_M_CAP_RISE) & rise)
        | ((r4_mode | r16_mode) & rise & wrap));           // RULE5

    // Prescaler count, cleared when not capturing
    assign cnt_next = clr_i ? 4'h0 :                       // RULE6
                      ((r4_mode | r16_mode) & rise) ? (wrap ? 4'h0 : cnt_reg + 4'h1) :
                      cnt_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_reg <= 1'b0;
            cnt_reg  <= 4'h0;                              // RULE6
        end else begin
            prev_reg <= in_i;
            cnt_reg  <= cnt_next;                              // RULE7
        end
    end

    property p_prescale_clear;
        @(posedge mclk_i) disable iff (!rstn_i)
        clr_i |=> (cnt_reg == 4'h0);
    endproperty
    a_prescale_clear: assert property (p_prescale_clear)   // RULE6
        else $error("prescaler count not cleared");
endmodule

// [hdl/ccp_pkg.sv]
// Types shared by the capture/compare/PWM channel
package ccp_pkg;
    typedef enum logic [1:0] {
        CCP_KIND_OFF,
        CCP_KIND_CAPT,
        CCP_KIND_CMP,
        CCP_KIND_PWM
    } ccp_kind_t;
endpackage

// [hdl/ccp_unit.sv]
// Capture/compare/PWM channel top level
// What this block does
// RULE1: Capture event copies timer count into value pair and sets flag; overwrites.
// RULE2: Mode field decodes off, five capture, six compare, four PWM codes.
// RULE3: Software keeps interrupt enable clear and clears flag after mode changes.
// RULE4: Capture timer must run from the instruction clock.
// RULE5: Four capture prescaler settings chosen by the mode field.
// RULE6: Prescaler counter cleared when off, not capturing, or in reset.
// RULE7: Prescaler switch keeps count; software writes zero control first.
// RULE8: Timer on instruction clock holds count in sleep, resumes after.
// RULE9: Capture keeps working in sleep with an external timer clock.
// RULE10: Compare value against timer each cycle; toggle, set, clear or flag.
// RULE11: Flag and ADC trigger set in the same cycle as pin action.
// RULE12: Writing zero control forces the output latch low.
// RULE13: Compare timer runs synchronously, never on undivided system clock.
// RULE14: Match removed before following edge cancels timer reset.
// RULE15: Compare needs running timer in sleep; enabled flag wakes device.
// RULE16: PWM mode makes a waveform with up to ten bits of duty.
// RULE17: Software clears pin direction control to drive PWM on the pin.
// RULE18: Software follows the given PWM setup order.
// RULE19: Software waits for period timer flag before enabling pin driver.
// RULE20: Each channel selects its own time base timer.
// RULE21: PWM time base timer counts the instruction clock.
// RULE22: PWM period comes from the period timer's period register only.
// RULE23: After period match: clear timer, set output unless duty zero, load duty.
// RULE24: Output cleared when ten-bit time base equals buffered duty.
// RULE25: Channel flag stays set until software clears it.
`timescale 1ns/1ps
`include "ccp_defs.svh"
module ccp_unit (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        ctrl_wr_i,
    input  wire logic [7:0]  ctrl_wdata_i,
    input  wire logic        val_lo_wr_i,
    input  wire logic        val_hi_wr_i,
    input  wire logic [7:0]  val_wdata_i,
    input  wire logic        flag_clr_i,
    input  wire logic        chan_irq_enable_i,
    input  wire logic        adc_trig_sel_i,
    input  wire logic        timer_sel_i,
    input  wire logic [15:0] timer_a_i,
    input  wire logic [15:0] timer_b_i,
    input  wire logic        sleep_i,
    input  wire logic        ext_timer_clk_i,
    input  wire logic        capture_in_i,
    input  wire logic [7:0]  period_timer_count_i,
    input  wire logic [7:0]  period_value_reg_i,
    input  wire logic        period_tick_i,
    input  wire logic [1:0]  base_low_i,
    output logic [7:0]       chan_control_reg_o,
    output logic [15:0]      chan_value_o,
    output logic             chan_pin_o,
    output logic             chan_event_flag_o,
    output logic             wake_o,
    output logic             adc_trig_o,
    output logic             timer_rst_o,
    output logic             period_clr_o
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [7:0]          ctrl_reg;
    logic [15:0]         value_reg;
    logic [9:0]          duty_reg;
    logic                out_reg;
    logic                flag_reg;
    logic                match_prev_reg;
    logic                rst_pend_reg;
    logic                wake_reg;
    logic                adc_reg;
    logic                trst_reg;
    logic                pclr_reg;
    logic [7:0]          ctrl_next;
    logic [15:0]         value_next;
    logic [9:0]          duty_next;
    logic                out_next;
    logic                flag_next;
    logic [3:0]          mode;
    logic                en;
    ccp_pkg::ccp_kind_t  kind;
    logic [15:0]         timer_val;
    logic                run;
    logic                cap_hit;
    logic                match;
    logic                cmp_hit;
    logic                pwm_roll;
    logic                pwm_clr;
    logic [9:0]          duty_new;
    logic [9:0]          time_base;
    logic                zero_wr;
    logic                rst_mode;
    logic                event_any;

    assign mode     = ctrl_reg[3:0];
    assign en       = ctrl_reg[`CCP_EN_BIT];
    assign kind     = (!en || mode == `CCP_M_OFF)         ? ccp_pkg::CCP_KIND_OFF :   // RULE2
                      (mode >= `CCP_M_PWM_LO)             ? ccp_pkg::CCP_KIND_PWM :
                      (mode >= `CCP_M_CAP_ANY && mode <= `CCP_M_CAP_R16)
                                                          ? ccp_pkg::CCP_KIND_CAPT :
                                                            ccp_pkg::CCP_KIND_CMP;
    assign timer_val = timer_sel_i ? timer_b_i : timer_a_i;                          // RULE20
    assign run       = ~sleep_i | ext_timer_clk_i;                                   // RULE9
    assign zero_wr   = ctrl_wr_i & (ctrl_wdata_i == 8'h00);
    assign rst_mode  = (mode == `CCP_M_TOG_CLR) | (mode == `CCP_M_PULSE_CLR);

    // ------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------
    ccp_edge_cnt u_edge (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .clr_i  (kind != ccp_pkg::CCP_KIND_CAPT),                                    // RULE6
        .run_i  (run),                                                               // RULE8
        .mode_i (mode),
        .in_i   (capture_in_i),
        .hit_o  (cap_hit)
    );

    // ------------------------------------------------------------
    // Compare
    // ------------------------------------------------------------
    assign match   = (timer_val == value_reg);                                       // RULE10
    assign cmp_hit = (kind == ccp_pkg::CCP_KIND_CMP) & run & match & ~match_prev_reg; // RULE15

    // ------------------------------------------------------------
    // PWM
    // ------------------------------------------------------------
    assign pwm_roll  = (kind == ccp_pkg::CCP_KIND_PWM) & period_tick_i & ~sleep_i
                     & (period_timer_count_i == period_value_reg_i);                 // RULE22
    assign duty_new  = ctrl_reg[`CCP_FMT_BIT] ? {value_reg[15:8], value_reg[7:6]}
                                             : value_reg[9:0];
    assign time_base = {period_timer_count_i, base_low_i};
    assign pwm_clr   = (kind == ccp_pkg::CCP_KIND_PWM) & ~pwm_roll
                     & (time_base == duty_reg);                                      // RULE24
    assign event_any = cap_hit | cmp_hit | pwm_roll;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign ctrl_next = ctrl_wr_i ? (ctrl_wdata_i & `CCP_CTRL_WMASK) : ctrl_reg;
    assign duty_next = pwm_roll ? duty_new : duty_reg;                               // RULE23

    always_comb begin
        value_next = value_reg;
        if (val_lo_wr_i) begin
            value_next[7:0] = val_wdata_i;
        end
        if (val_hi_wr_i) begin
            value_next[15:8] = val_wdata_i;
        end
        if (cap_hit) begin
            value_next = timer_val;                                                  // RULE1
        end
    end

    always_comb begin
        out_next = out_reg;
        unique case (kind)
            ccp_pkg::CCP_KIND_OFF: begin
                out_next = 1'b0;
            end
            ccp_pkg::CCP_KIND_CAPT: begin
                out_next = out_reg;
            end
            ccp_pkg::CCP_KIND_CMP: begin
                if (mode == `CCP_M_PULSE || mode == `CCP_M_PULSE_CLR) begin
                    out_next = cmp_hit;
                end else if (cmp_hit) begin
                    if (mode == `CCP_M_SET) begin
                        out_next = 1'b1;                                             // RULE10
                    end else if (mode == `CCP_M_CLR) begin
                        out_next = 1'b0;
                    end else begin
                        out_next = ~out_reg;
                    end
                end
            end
            ccp_pkg::CCP_KIND_PWM: begin
                if (pwm_roll) begin
                    out_next = (duty_new != 10'h000);                                // RULE23
                end else if (pwm_clr) begin
                    out_next = 1'b0;                                                 // RULE24
                end
            end
        endcase
        if (zero_wr) begin
            out_next = 1'b0;                                                         // RULE12
        end
    end

    // Set wins over a software clear in the same cycle
    assign flag_next = event_any | (flag_reg & ~flag_clr_i);                         // RULE25

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg       <= `CCP_CTRL_RST;
            value_reg      <= `CCP_VALUE_RST;
            duty_reg       <= `CCP_DUTY_RST;
            out_reg        <= 1'b0;
            flag_reg       <= 1'b0;
            match_prev_reg <= 1'b0;
            rst_pend_reg   <= 1'b0;
        end else begin
            ctrl_reg       <= ctrl_next;
            value_reg      <= value_next;
            duty_reg       <= duty_next;
            out_reg        <= out_next;
            flag_reg       <= flag_next;                                             // RULE11
            match_prev_reg <= match;
            rst_pend_reg   <= cmp_hit & rst_mode;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_reg <= 1'b0;
            adc_reg  <= 1'b0;
            trst_reg <= 1'b0;
            pclr_reg <= 1'b0;
        end else begin
            wake_reg <= flag_next & chan_irq_enable_i;                               // RULE15
            adc_reg  <= event_any & adc_trig_sel_i;                                  // RULE11
            trst_reg <= rst_pend_reg & match & (kind == ccp_pkg::CCP_KIND_CMP);      // RULE14
            pclr_reg <= pwm_roll;                                                    // RULE23
        end
    end

    assign chan_control_reg_o = {ctrl_reg[7:6], out_reg, ctrl_reg[4:0]};
    assign chan_value_o       = value_reg;
    assign chan_pin_o         = out_reg;                                             // RULE16
    assign chan_event_flag_o  = flag_reg;
    assign wake_o             = wake_reg;
    assign adc_trig_o         = adc_reg;
    assign timer_rst_o        = trst_reg;
    assign period_clr_o       = pclr_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_capture_copy;
        @(posedge mclk_i) disable iff (!rstn_i)
        cap_hit |=> (chan_value_o == $past(timer_val)) && chan_event_flag_o;
    endproperty
    a_capture_copy: assert property (p_capture_copy)                                  // RULE1
        else $error("capture did not copy timer or set flag");

    property p_off_low;
        @(posedge mclk_i) disable iff (!rstn_i)
        (kind == ccp_pkg::CCP_KIND_OFF) |=> !chan_pin_o;
    endproperty
    a_off_low: assert property (p_off_low)                                            // RULE2
        else $error("output high while channel off");

    property p_set_on_match;
        @(posedge mclk_i) disable iff (!rstn_i)
        (cmp_hit && mode == `CCP_M_SET && !zero_wr) |=> chan_pin_o;
    endproperty
    a_set_on_match: assert property (p_set_on_match)                                  // RULE10
        else $error("set-on-match did not set output");

    property p_toggle;
        @(posedge mclk_i) disable iff (!rstn_i)
        (cmp_hit && mode == `CCP_M_TOG && !zero_wr) |=> (chan_pin_o != $past(chan_pin_o));
    endproperty
    a_toggle: assert property (p_toggle)                                              // RULE10
        else $error("toggle-on-match did not toggle");

    property p_flag_adc_together;
        @(posedge mclk_i) disable iff (!rstn_i)
        (cmp_hit && adc_trig_sel_i) |=> chan_event_flag_o && adc_trig_o;
    endproperty
    a_flag_adc_together: assert property (p_flag_adc_together)                        // RULE11
        else $error("flag and trigger not raised together");

    property p_zero_write;
        @(posedge mclk_i) disable iff (!rstn_i)
        zero_wr |=> !chan_pin_o && (chan_control_reg_o == 8'h00);
    endproperty
    a_zero_write: assert property (p_zero_write)                                      // RULE12
        else $error("zero control write left output high");

    property p_reset_cancel;
        @(posedge mclk_i) disable iff (!rstn_i)
        (cmp_hit && rst_mode) ##1 !match |=> !timer_rst_o;
    endproperty
    a_reset_cancel: assert property (p_reset_cancel)                                  // RULE14
        else $error("timer reset issued after match removed");

    property p_pwm_roll;
        @(posedge mclk_i) disable iff (!rstn_i)
        (pwm_roll && !zero_wr) |=> period_clr_o && (duty_reg == $past(duty_new))
                                  && (chan_pin_o == ($past(duty_new) != 10'h000));
    endproperty
    a_pwm_roll: assert property (p_pwm_roll)                                          // RULE23
        else $error("period rollover actions wrong");

    property p_pwm_clear;
        @(posedge mclk_i) disable iff (!rstn_i)
        pwm_clr |=> !chan_pin_o;
    endproperty
    a_pwm_clear: assert property (p_pwm_clear)                                        // RULE24
        else $error("duty match did not clear output");

    property p_flag_sticky;
        @(posedge mclk_i) disable iff (!rstn_i)
        (chan_event_flag_o && !flag_clr_i) |=> chan_event_flag_o;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)                                    // RULE25
        else $error("flag cleared without software");

    property p_wake;
        @(posedge mclk_i) disable iff (!rstn_i)
        (cmp_hit && chan_irq_enable_i) |=> wake_o;
    endproperty
    a_wake: assert property (p_wake)                                                  // RULE15
        else $error("enabled flag did not wake");

    property p_cov_capture;
        @(posedge mclk_i) disable iff (!rstn_i)
        (mode == `CCP_M_CAP_R16) && cap_hit;
    endproperty
    c_cov_capture: cover property (p_cov_capture);

    property p_cov_reset;
        @(posedge mclk_i) disable iff (!rstn_i)
        timer_rst_o;
    endproperty
    c_cov_reset: cover property (p_cov_reset);

    property p_cov_pwm;
        @(posedge mclk_i) disable iff (!rstn_i)
        pwm_roll ##[1:1000] pwm_clr;
    endproperty
    c_cov_pwm: cover property (p_cov_pwm);
endmodule

// [test/capture_compare_pwm_unit_test.sv]
// Self-checking bench for the capture/compare/PWM channel
`timescale 1ns/1ps
module capture_compare_pwm_unit_test;
    logic        mclk_i = 1'h0;
    logic        rstn_i = 1'h0;
    logic        ctrl_wr = 1'h0;
    logic [7:0]  ctrl_wd = 8'h00;
    logic        lo_wr = 1'h0;
    logic        hi_wr = 1'h0;
    logic [7:0]  val_wd = 8'h00;
    logic        flag_clr = 1'h0;
    logic        irq_en = 1'h0;
    logic        adc_sel = 1'h0;
    logic        tsel = 1'h0;
    logic        sleep = 1'h0;
    logic        ext_clk = 1'h0;
    logic        cap_in = 1'h0;
    logic        run = 1'h0;
    logic        load = 1'h0;
    logic [15:0] load_val = 16'h0000;
    logic [7:0]  pr = 8'h03;
    logic [15:0] tmr_a, tmr_b, value, expv, v;
    logic [7:0]  pcnt, ctrl_rb;
    logic [1:0]  blow;
    logic        ptick, pin, flag, wake, adc_trig, timer_rst, period_clr;
    int          num_errors = 0;
    int          check_count = 0;
    int          h6, h2, hl, pc;
    logic [7:0]  cap_ctrl [7] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'hE5, 8'h00};
    logic [7:0]  cap_rb   [7] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h85, 8'h00};
    logic        cap_fr   [7] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    logic        cap_ff   [7] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
    logic [7:0]  cmp_ctrl [6] = '{8'h81, 8'h82, 8'h88, 8'h89, 8'h8A, 8'h8B};
    logic        cmp_hit  [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
    logic        cmp_aft  [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
    logic        cmp_rst  [6] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};

    ccp_unit DUT (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wd),
        .val_lo_wr_i(lo_wr), .val_hi_wr_i(hi_wr), .val_wdata_i(val_wd),
        .flag_clr_i(flag_clr), .chan_irq_enable_i(irq_en), .adc_trig_sel_i(adc_sel),
        .timer_sel_i(tsel), .timer_a_i(tmr_a), .timer_b_i(tmr_b), .sleep_i(sleep),
        .ext_timer_clk_i(ext_clk), .capture_in_i(cap_in), .period_timer_count_i(pcnt),
        .period_value_reg_i(pr), .period_tick_i(ptick), .base_low_i(blow),
        .chan_control_reg_o(ctrl_rb), .chan_value_o(value), .chan_pin_o(pin),
        .chan_event_flag_o(flag), .wake_o(wake), .adc_trig_o(adc_trig),
        .timer_rst_o(timer_rst), .period_clr_o(period_clr)
    );

    ccp_timer_model timers (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .run_i(run), .sleep_i(sleep), .load_i(load),
        .load_val_i(load_val), .timer_rst_i(timer_rst), .period_value_reg_i(pr),
        .timer_a_o(tmr_a), .timer_b_o(tmr_b), .period_timer_count_o(pcnt),
        .period_tick_o(ptick), .base_low_o(blow)
    );

    always #25 mclk_i = ~mclk_i;

    // ------------------------------------------------------------
    // Stimulus and checking tasks, entered at a falling edge
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic do_reset();
        rstn_i = 1'h0;
        cyc(20);
        rstn_i = 1'h1;
        cyc(2);
        check(value, 16'h0000);
        check({ctrl_rb, pin, flag, wake, adc_trig, timer_rst, period_clr}, 16'h0000);
    endtask

    task automatic wr_ctrl(input logic [7:0] d);
        ctrl_wr = 1'h1;
        ctrl_wd = d;
        cyc(1);
        ctrl_wr = 1'h0;
        cyc(1);
    endtask

    task automatic wr_val(input logic [15:0] d);
        lo_wr = 1'h1;
        val_wd = d[7:0];
        cyc(1);
        lo_wr = 1'h0;
        hi_wr = 1'h1;
        val_wd = d[15:8];
        cyc(1);
        hi_wr = 1'h0;
        cyc(1);
    endtask

    task automatic clr_flag();
        flag_clr = 1'h1;
        cyc(1);
        flag_clr = 1'h0;
        cyc(1);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            cap_in = 1'h1;
            cyc(2);
            cap_in = 1'h0;
            cyc(2);
        end
    endtask

    task automatic tload(input logic [15:0] d);
        load = 1'h1;
        load_val = d;
        cyc(1);
        load = 1'h0;
    endtask

    task automatic wait_flag();
        int k;
        k = 0;
        while (flag !== 1'h1) begin
            k++;
            if (k > 200) begin
                num_errors++;
                report_and_stop();
            end
            cyc(1);
        end
    endtask

    task automatic pwm_run(input logic [7:0] c, input logic [15:0] d, output int hi,
                           output int pcs);
        wr_ctrl(8'h00);
        wr_ctrl(c);
        wr_val(d);
        cyc(48);
        hi = 0;
        pcs = 0;
        repeat (64) begin
            cyc(1);
            hi += (pin === 1'h1);
            pcs += (period_clr === 1'h1);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(1);
        do_reset();
        expv = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            wr_ctrl(8'h00);
            wr_ctrl(cap_ctrl[i]);
            check(ctrl_rb, cap_rb[i]);
            tload({8'hA0, 8'(i)});
            clr_flag();
            cap_in = 1'h1;
            cyc(3);
            check(flag, cap_fr[i]);
            if (cap_fr[i]) expv = {8'hA0, 8'(i)};
            clr_flag();
            cap_in = 1'h0;
            cyc(3);
            check(flag, cap_ff[i]);
            if (cap_ff[i]) expv = {8'hA0, 8'(i)};
            check(value, expv);
        end
        wr_ctrl(8'h86);
        clr_flag();
        pulses(3);
        wr_ctrl(8'h00);
        wr_ctrl(8'h86);
        clr_flag();
        pulses(3);
        check(flag, 1'h0);
        pulses(1);
        check(flag, 1'h1);
        wr_ctrl(8'h00);
        wr_ctrl(8'h87);
        clr_flag();
        pulses(15);
        check(flag, 1'h0);
        pulses(1);
        check(flag, 1'h1);
        wr_ctrl(8'h00);
        wr_ctrl(8'h85);
        clr_flag();
        sleep = 1'h1;
        pulses(1);
        check(flag, 1'h0);
        ext_clk = 1'h1;
        pulses(1);
        check(flag, 1'h1);
        sleep = 1'h0;
        ext_clk = 1'h0;
        irq_en = 1'h1;
        cyc(20);
        check({flag, wake}, 2'h3);
        clr_flag();
        cyc(1);
        check(wake, 1'h0);
        for (int i = 0; i < 6; i++) begin
            v = 16'h0040 + 16'(i);
            tsel = (i == 5);
            adc_sel = i[0];
            wr_val(v);
            wr_ctrl(cmp_ctrl[i]);
            clr_flag();
            tload(tsel ? ~v : v);
            wait_flag();
            check({pin, adc_trig}, {cmp_hit[i], adc_sel});
            cyc(1);
            check({pin, timer_rst, wake}, {cmp_aft[i], cmp_rst[i], 1'h1});
        end
        tsel = 1'h0;
        wr_val(16'h0050);
        wr_ctrl(8'h88);
        tload(16'h0050);
        cyc(4);
        check(pin, 1'h1);
        wr_ctrl(8'h00);
        check(pin, 1'h0);
        wr_val(16'h0060);
        wr_ctrl(8'h81);
        tload(16'h0060);
        wr_val(16'h0061);
        cyc(1);
        check(tmr_a, 16'h0060);
        check(pin, 1'h1);
        run = 1'h1;
        pwm_run(8'h8C, 16'h0006, h6, pc);
        check(16'(pc), 16'h0004);
        pwm_run(8'h8C, 16'h0002, h2, pc);
        check(16'(h6 - h2), 16'h0010);
        pwm_run(8'h9F, 16'h0180, hl, pc);
        check(16'(hl), 16'(h6));
        pwm_run(8'h8C, 16'h0000, hl, pc);
        check(16'(hl), 16'h0000);
        pwm_run(8'h8C, 16'h0014, hl, pc);
        check(16'(hl), 16'h0040);
        run = 1'h0;
        wr_ctrl(8'h00);
        wr_ctrl(8'h86);
        pulses(2);
        do_reset();
        wr_ctrl(8'h86);
        clr_flag();
        pulses(3);
        check(flag, 1'h0);
        report_and_stop();
    end
endmodule

// [test/ccp_timer_model.sv]
// Partner timers: capture/compare timer and PWM period timer
`timescale 1ns/1ps
module ccp_timer_model (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        run_i,
    input  wire logic        sleep_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_val_i,
    input  wire logic        timer_rst_i,
    input  wire logic [7:0]  period_value_reg_i,
    output logic [15:0]      timer_a_o,
    output logic [15:0]      timer_b_o,
    output logic [7:0]       period_timer_count_o,
    output logic             period_tick_o,
    output logic [1:0]       base_low_o
);
    logic step;

    // Both timers count the instruction clock and freeze in sleep
    assign step          = run_i && !sleep_i;
    assign timer_b_o     = ~timer_a_o;
    assign period_tick_o = step && (base_low_o == 2'h3);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_a_o            <= 16'h0000;
            period_timer_count_o <= 8'h00;
            base_low_o           <= 2'h0;
        end else begin
            if (load_i) begin
                timer_a_o <= load_val_i;
            end else if (timer_rst_i) begin
                timer_a_o <= 16'h0000;
            end else if (step) begin
                timer_a_o <= timer_a_o + 16'h0001;
            end
            if (step) begin
                base_low_o <= base_low_o + 2'h1;
            end
            // Wrap after the count equals the period value
            if (period_tick_o) begin
                period_timer_count_o <= (period_timer_count_o == period_value_reg_i) ?
                                        8'h00 : period_timer_count_o + 8'h01;
            end
        end
    end
endmodule
